// ---- bench/p2m_board.sv ----
`timescale 1ns/10ps
`default_nettype none
// External circuitry on the six bonded pins.
module p2m_board (
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe_o,
  input  wire logic [5:0] ext_lvl_i,
  output logic      [5:0] pin_i
);
  // The board drives every pin that the device leaves released.
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_lvl_i);
endmodule // p2m_board
`default_nettype wire

// ---- bench/p2m_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// Port relations kept by the pin multiplexer.
module p2m_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe_o,
  input wire logic [5:0] analog_en_o,
  input wire logic [1:0] segment_active_o,
  input wire logic [1:0] lcd_segment_i,
  input wire logic       timer_ch2_capture_input_a_o,
  input wire logic       usart_serial_clock_o,
  input wire logic       usart_slave_transmit_enable_o,
  input wire logic       usart_receive_line_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A taken request gets one ack pulse on the next cycle.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_ack_src;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack unasked");
  property p_seg_drv;
    segment_active_o[0] |-> pin_oe_o[1:0] == 2'b11
      && pin_o[1:0] == $past(lcd_segment_i);
  endproperty
  a_seg_drv: assert property (p_seg_drv) else $error("segment drive");
  property p_seg_pair;
    segment_active_o[0] == segment_active_o[1] && analog_en_o[1:0] == 2'b00;
  endproperty
  a_seg_pair: assert property (p_seg_pair) else $error("segment pair");
  property p_ana_off;
    (analog_en_o[5:2] & pin_oe_o[5:2]) == 4'h0;
  endproperty
  a_ana_off: assert property (p_ana_off) else $error("analog drive");
  property p_ste_in;
    usart_slave_transmit_enable_o |-> !pin_oe_o[2];
  endproperty
  a_ste_in: assert property (p_ste_in) else $error("ste pin driven");
  property p_rxd_in;
    !usart_receive_line_o |-> !pin_oe_o[5];
  endproperty
  a_rxd_in: assert property (p_rxd_in) else $error("rxd pin driven");
  property p_clk_in;
    usart_serial_clock_o |-> !pin_oe_o[1];
  endproperty
  a_clk_in: assert property (p_clk_in) else $error("clock pin driven");
  property p_cap_seg;
    timer_ch2_capture_input_a_o |-> !segment_active_o[0];
  endproperty
  a_cap_seg: assert property (p_cap_seg) else $error("capture in seg");
endmodule // p2m_sva
bind p2m_mux p2m_sva i_p2m_sva (.*);
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the pin function multiplexer.
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [5:0]  pin_i, pin_o, pin_oe_o, analog_en_o;
  logic [5:0]  ext_lvl_i = 6'h00;
  logic [1:0]  segment_active_o;
  logic [1:0]  lcd_segment_i = 2'h0;
  logic        timer_ch2_output_signal_i = 1'b0;
  logic        timer_ch2_capture_input_a_o;
  logic        usart_clock_direction_control_i = 1'b0;
  logic        usart_serial_clock_i = 1'b0;
  logic        usart_serial_clock_o;
  logic        usart_slave_transmit_enable_o;
  logic        usart_transmit_line_i = 1'b0;
  logic        usart_receive_line_o;
  logic        irq_o;
  logic [7:0]  sel, dir, out, ies;
  logic [3:0]  cid, vld;
  logic [2:0]  lcdp;
  logic [5:0]  eo, ev, ea, w, po, pv, a, b, fl;
  logic        seg, ck;
  logic [31:0] q;
  int          errors = 0;
  int          checked = 0;
  p2m_mux   i_p2m_mux (.*);
  p2m_board i_p2m_board (.*);
  // Clock of 100 ns period.
  initial forever #50 clk_i = ~clk_i;
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle, released at the edge that sees ack.
  task automatic bus(input logic [7:0] ad, input logic we,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      give_verdict();
    end else begin
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  // Reads a register and compares it.
  task automatic rdc(input string nm, input logic [7:0] ad,
                     input logic [31:0] e);
    bus(ad, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // Writes a register and reads back its stored bits.
  task automatic wrc(input string nm, input logic [7:0] ad,
                     input logic [31:0] d, input logic [31:0] m);
    bus(ad, 1'b1, d);
    rdc(nm, ad, d & m);
  endtask
  // Waits out pin drive, both synchroniser stages and the output register.
  // Outputs are read before the last edge updates them, hence the margin.
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask
  // Reference model of pin drive, analog ownership and wire level.
  task automatic calc();
    seg = (lcdp >= 3'h4);
    ea = {cid[3], cid[2], vld == 4'hF, cid[0], 2'b00};
    po = {1'b0, 1'b1, dir[3], 1'b0, usart_clock_direction_control_i, dir[0]};
    pv = {1'b0, usart_transmit_line_i, 2'b00, usart_serial_clock_i,
          timer_ch2_output_signal_i};
    eo = (sel[5:0] & po) | (~sel[5:0] & dir[5:0]);
    ev = (sel[5:0] & pv) | (~sel[5:0] & out[5:0]);
    if (seg) begin
      eo[1:0] = 2'b11;
      ev[1:0] = lcd_segment_i;
    end
    eo = eo & ~ea;
    w = (eo & ev) | (~eo & ext_lvl_i);
  endtask
  // Main sequence: reset values, random muxing, then edge flags.
  initial begin
    void'($urandom(32'hA48A));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k <= 32; k += 4) rdc("reset", 8'(k), 32'h0);
    bus(8'h40, 1'b1, 32'hFFFFFFFF);
    rdc("unmapped", 8'h40, 32'h0);
    wb_sel_i <= 4'h0;
    bus(p2m_pkg::OFF_SEL, 1'b1, 32'hFF);
    wb_sel_i <= 4'hF;
    rdc("lane", p2m_pkg::OFF_SEL, 32'h0);
    for (int i = 0; i < 32; i++) begin
      sel = 8'($urandom);
      dir = 8'($urandom);
      out = 8'($urandom);
      cid = 4'($urandom);
      vld = (i % 5 == 0) ? 4'hF : 4'($urandom);
      lcdp = 3'(i);
      wrc("sel", p2m_pkg::OFF_SEL, {24'h0, sel}, 32'hFF);
      wrc("dir", p2m_pkg::OFF_DIR, {24'h0, dir}, 32'hFF);
      wrc("out", p2m_pkg::OFF_OUT, {24'h0, out}, 32'hFF);
      wrc("cfg", p2m_pkg::OFF_CFG,
          {16'h0, vld, 1'b0, lcdp, 2'b0, cid, 2'b0}, 32'hF73C);
      ext_lvl_i <= 6'($urandom);
      lcd_segment_i <= 2'($urandom);
      timer_ch2_output_signal_i <= 1'($urandom);
      usart_clock_direction_control_i <= 1'($urandom);
      usart_serial_clock_i <= 1'($urandom);
      usart_transmit_line_i <= 1'($urandom);
      settle();
      calc();
      chk("oe", eo, pin_oe_o);
      chk("pin", eo & ev, eo & pin_o);
      chk("analog", ea, analog_en_o);
      chk("segment", {2{seg}}, segment_active_o);
      chk("ste", {sel[2] & ~ea[2] & w[2]}, usart_slave_transmit_enable_o);
      chk("rxd", {~(sel[5] & ~ea[5]) | w[5]}, usart_receive_line_o);
      ck = sel[1] & ~seg & ~usart_clock_direction_control_i & w[1];
      chk("uclk", {ck}, usart_serial_clock_o);
      chk("cap", {sel[0] & ~seg & w[0]}, timer_ch2_capture_input_a_o);
      rdc("in", p2m_pkg::OFF_IN, {26'h0, w & ~ea & ~{4'h0, {2{seg}}}});
      rdc("sts", p2m_pkg::OFF_STS, {26'h0, ea | {5'h0, seg}});
    end
    bus(p2m_pkg::OFF_CFG, 1'b1, 32'h0);
    bus(p2m_pkg::OFF_SEL, 1'b1, 32'h0);
    bus(p2m_pkg::OFF_DIR, 1'b1, 32'h0);
    bus(p2m_pkg::OFF_IE, 1'b1, 32'hFF);
    for (int i = 0; i < 6; i++) begin
      a = 6'($urandom);
      b = 6'($urandom);
      ies = 8'($urandom);
      wrc("ies", p2m_pkg::OFF_IES, {24'h0, ies}, 32'hFF);
      ext_lvl_i <= a;
      settle();
      bus(p2m_pkg::OFF_IFG, 1'b1, 32'h0);
      ext_lvl_i <= b;
      settle();
      fl = (~ies[5:0] & ~a & b) | (ies[5:0] & a & ~b);
      rdc("ifg", p2m_pkg::OFF_IFG, {26'h0, fl});
      chk("irq", {fl != 6'h0}, irq_o);
      wrc("soft flag", p2m_pkg::OFF_IFG, 32'hC0, 32'hFF);
      chk("irq soft", 1'b1, irq_o);
      bus(p2m_pkg::OFF_IE, 1'b1, 32'h3F);
      @(posedge clk_i);
      chk("irq masked", 1'b0, irq_o);
      bus(p2m_pkg::OFF_IE, 1'b1, 32'hFF);
    end
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ---- rtl/p2m_mux.sv ----
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// Pin function multiplexer for the second eight-bit port.
module p2m_mux (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Bonded pins.
  input  wire logic [5:0]  pin_i,
  output logic      [5:0]  pin_o,
  output logic      [5:0]  pin_oe_o,
  output logic      [5:0]  analog_en_o,
  output logic      [1:0]  segment_active_o,
  input  wire logic [1:0]  lcd_segment_i,
  // Peripherals.
  input  wire logic        timer_ch2_output_signal_i,
  output logic             timer_ch2_capture_input_a_o,
  input  wire logic        usart_clock_direction_control_i,
  input  wire logic        usart_serial_clock_i,
  output logic             usart_serial_clock_o,
  output logic             usart_slave_transmit_enable_o,
  input  wire logic        usart_transmit_line_i,
  output logic             usart_receive_line_o,
  // Interrupt request.
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------

  // Address match for one register.
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // Byte-lane merge of one write lane into a stored byte.
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [7:0] wr,
                                      input logic       en);
    lane = en ? wr : old;
  endfunction

  // ----------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------
  logic [7:0] pin_function_select_reg;
  logic [7:0] pin_direction_reg;
  logic [7:0] pin_output_level_reg;
  logic [7:0] pin_irq_enable_reg;
  logic [7:0] pin_irq_flag_reg;
  logic [7:0] pin_irq_flag_next;
  logic [7:0] pin_edge_select_reg;
  logic [3:0] comparator_input_disable_reg;
  logic [p2m_pkg::LCDP_W-1:0] lcd_port_count_field_reg;
  logic [p2m_pkg::VLD_W-1:0]  supervisor_level_select_reg;
  logic       ack_reg;
  logic [31:0] dat_reg;

  logic [5:0] lvl;
  logic [5:0] rise;
  logic [5:0] fall;
  logic       port_vs_segment_select;
  logic [5:0] digital_en;
  logic [7:0] pin_input_level;
  logic [7:0] edge_set;
  logic       wr_go;
  logic       rd_go;
  logic [31:0] rd_data;
  logic [5:0] pin_next;
  logic [5:0] oe_next;

  // ----------------------------------------------------------------
  // Input synchroniser.
  // ----------------------------------------------------------------
  p2m_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (pin_i),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // ----------------------------------------------------------------
  // Digital path enables.
  // ----------------------------------------------------------------

  // Segment drive takes bits 0 and 1 once the count field reaches 04h.
  assign port_vs_segment_select =
    (lcd_port_count_field_reg >= p2m_pkg::LCDP_SEG);

  // Bits 0 and 1 share the segment enable condition; bits 2 to 5 each own one.
  always_comb begin
    digital_en[0] = ~port_vs_segment_select;
    digital_en[1] = ~port_vs_segment_select;
    digital_en[2] = ~comparator_input_disable_reg[0];
    digital_en[3] = (supervisor_level_select_reg
                     != p2m_pkg::VLD_EXTERN);
    digital_en[4] = ~comparator_input_disable_reg[2];
    digital_en[5] = ~comparator_input_disable_reg[3];
  end

  // Bit 1 of the disable field is kept but the supervisor decides bit 3.
  // Unbonded bits read low; disabled bits read low as well.
  assign pin_input_level = {2'b00, lvl & digital_en};

  // ----------------------------------------------------------------
  // Pin drive selection.
  // ----------------------------------------------------------------

  // Chooses level and enable per pin from segment, peripheral or port.
  always_comb begin
    pin_next = '0;
    oe_next  = '0;
    for (int i = 0; i < 6; i++) begin
      if (!digital_en[i]) begin
        if (i < 2) begin
          pin_next[i] = lcd_segment_i[i[0]];
          oe_next[i]  = 1'b1;
        end
      end else if (!pin_function_select_reg[i]) begin
        pin_next[i] = pin_output_level_reg[i];
        oe_next[i]  = pin_direction_reg[i];
      end else begin
        case (i)
          0: begin
            pin_next[i] = timer_ch2_output_signal_i;
            oe_next[i]  = pin_direction_reg[i];
          end
          1: begin
            pin_next[i] = usart_serial_clock_i;
            oe_next[i]  = usart_clock_direction_control_i;
          end
          3: begin
            pin_next[i] = 1'b0;
            oe_next[i]  = pin_direction_reg[i];
          end
          4: begin
            pin_next[i] = usart_transmit_line_i;
            oe_next[i]  = 1'b1;
          end
          default: begin
            pin_next[i] = 1'b0;
            oe_next[i]  = 1'b0;
          end
        endcase
      end
    end
  end

  // Pin drive and analog hand-over are registered.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o            <= '0;
      pin_oe_o         <= '0;
      analog_en_o      <= '0;
      segment_active_o <= '0;
    end else begin
      pin_o            <= pin_next;
      pin_oe_o         <= oe_next;
      analog_en_o      <= {~digital_en[5:2], 2'b00};
      segment_active_o <= {2{port_vs_segment_select}};
    end
  end

  // ----------------------------------------------------------------
  // Peripheral inputs.
  // ----------------------------------------------------------------

  // Routes the synchronised pin levels to the peripherals.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ch2_capture_input_a_o   <= 1'b0;
      usart_serial_clock_o          <= 1'b0;
      usart_slave_transmit_enable_o <= 1'b0;
      usart_receive_line_o          <= 1'b1;
    end else begin
      timer_ch2_capture_input_a_o <= digital_en[0]
        & pin_function_select_reg[0] & lvl[0];
      usart_serial_clock_o <= digital_en[1] & pin_function_select_reg[1]
        & ~usart_clock_direction_control_i & lvl[1];
      usart_slave_transmit_enable_o <= digital_en[2]
        & pin_function_select_reg[2] & lvl[2];
      usart_receive_line_o <= (digital_en[5] & pin_function_select_reg[5])
        ? lvl[5] : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus access.
  // ----------------------------------------------------------------
  assign rd_go = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_go = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(wb_adr_i, p2m_pkg::OFF_SEL)) begin
      rd_data[7:0] = pin_function_select_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_DIR)) begin
      rd_data[7:0] = pin_direction_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_OUT)) begin
      rd_data[7:0] = pin_output_level_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_IN)) begin
      rd_data[7:0] = pin_input_level;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_IE)) begin
      rd_data[7:0] = pin_irq_enable_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_IFG)) begin
      rd_data[7:0] = pin_irq_flag_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_IES)) begin
      rd_data[7:0] = pin_edge_select_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_CFG)) begin
      rd_data[p2m_pkg::CFG_CID_MSB:p2m_pkg::CFG_CID_LSB] =
        comparator_input_disable_reg;
      rd_data[p2m_pkg::CFG_LCDP_LSB +: p2m_pkg::LCDP_W] =
        lcd_port_count_field_reg;
      rd_data[p2m_pkg::CFG_VLD_LSB +: p2m_pkg::VLD_W] =
        supervisor_level_select_reg;
    end else if (hit(wb_adr_i, p2m_pkg::OFF_STS)) begin
      rd_data[0]   = port_vs_segment_select;
      rd_data[7:2] = {2'b00, ~digital_en[5:2]};
    end
  end

  // Acknowledge one cycle after the request, then drop it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= rd_go;
      if (rd_go) begin
        dat_reg <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ----------------------------------------------------------------
  // Port control registers.
  // ----------------------------------------------------------------

  // Plain control bytes; all eight bits exist for unbonded bits too.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_function_select_reg <= p2m_pkg::PORT_RST;
      pin_direction_reg       <= p2m_pkg::PORT_RST;
      pin_output_level_reg    <= p2m_pkg::PORT_RST;
      pin_irq_enable_reg      <= p2m_pkg::PORT_RST;
      pin_edge_select_reg     <= p2m_pkg::PORT_RST;
    end else if (wr_go) begin
      if (hit(wb_adr_i, p2m_pkg::OFF_SEL)) begin
        pin_function_select_reg <= lane(pin_function_select_reg,
                                        wb_dat_i[7:0], wb_sel_i[0]);
      end else if (hit(wb_adr_i, p2m_pkg::OFF_DIR)) begin
        pin_direction_reg <= lane(pin_direction_reg,
                                  wb_dat_i[7:0], wb_sel_i[0]);
      end else if (hit(wb_adr_i, p2m_pkg::OFF_OUT)) begin
        pin_output_level_reg <= lane(pin_output_level_reg,
                                     wb_dat_i[7:0], wb_sel_i[0]);
      end else if (hit(wb_adr_i, p2m_pkg::OFF_IE)) begin
        pin_irq_enable_reg <= lane(pin_irq_enable_reg,
                                   wb_dat_i[7:0], wb_sel_i[0]);
      end else if (hit(wb_adr_i, p2m_pkg::OFF_IES)) begin
        pin_edge_select_reg <= lane(pin_edge_select_reg,
                                    wb_dat_i[7:0], wb_sel_i[0]);
      end
    end
  end

  // Analog, segment and supervisor configuration.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comparator_input_disable_reg <= p2m_pkg::CID_RST;
      lcd_port_count_field_reg     <= p2m_pkg::LCDP_RST;
      supervisor_level_select_reg  <= p2m_pkg::VLD_RST;
    end else if (wr_go && hit(wb_adr_i, p2m_pkg::OFF_CFG)) begin
      if (wb_sel_i[0]) begin
        comparator_input_disable_reg <=
          wb_dat_i[p2m_pkg::CFG_CID_MSB:p2m_pkg::CFG_CID_LSB];
      end
      if (wb_sel_i[1]) begin
        lcd_port_count_field_reg <=
          wb_dat_i[p2m_pkg::CFG_LCDP_LSB +: p2m_pkg::LCDP_W];
        supervisor_level_select_reg <=
          wb_dat_i[p2m_pkg::CFG_VLD_LSB +: p2m_pkg::VLD_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags.
  // ----------------------------------------------------------------

  // Edge events only for bonded bits with an active digital path.
  always_comb begin
    edge_set = 8'h00;
    for (int i = 0; i < 6; i++) begin
      edge_set[i] = digital_en[i] & (pin_edge_select_reg[i]
                    ? fall[i] : rise[i]);
    end
  end

  // Software writes the flags; a hardware edge in the same cycle wins.
  always_comb begin
    pin_irq_flag_next = pin_irq_flag_reg;
    if (wr_go && hit(wb_adr_i, p2m_pkg::OFF_IFG)) begin
      pin_irq_flag_next = lane(pin_irq_flag_reg,
                               wb_dat_i[7:0], wb_sel_i[0]);
    end
    pin_irq_flag_next = pin_irq_flag_next | edge_set;
  end

  // Flag storage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_irq_flag_reg <= p2m_pkg::PORT_RST;
    end else begin
      pin_irq_flag_reg <= pin_irq_flag_next;
    end
  end

  // One request line for all enabled flags, software ones included.
  assign irq_o = |(pin_irq_flag_reg & pin_irq_enable_reg);

endmodule // p2m_mux

`default_nettype wire

// ---- rtl/p2m_pkg.sv ----
// Functional notes
// - Bits 0 and 1 reach port or peripheral logic only while segment select is 0.
// - Segment select is 1 when the LCD port-count field is 04h or greater.
// - Bits 2, 4 and 5 have a digital path only while comparator disable is 0.
// - Bit 0 peripheral keeps port direction for timer channel 2 output, feeds capture input A.
// - Bit 1 peripheral lets the USART choose direction and carry its clock.
// - Bit 2 peripheral forces input and feeds the USART slave transmit enable.
// - Bit 4 peripheral forces output driven by the USART transmit line.
// - Bit 5 peripheral forces input, output low, feeds USART receive line.
// - Bit 3 loses its digital path when supervisor level select is 1111b.
// - Flags of unbonded bits 6 and 7 change only by software writes.
// - Bits 6 and 7 keep all control bits but have no pin or peripheral output.

package p2m_pkg;

  // ----------------------------------------------------------------
  // Widths.
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int PIN_W  = 6;
  localparam int LCDP_W = 3;
  localparam int VLD_W  = 4;

  // ----------------------------------------------------------------
  // Register byte offsets on the bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_OUT = 8'h08;
  localparam logic [7:0] OFF_IN  = 8'h0C;
  localparam logic [7:0] OFF_IE  = 8'h10;
  localparam logic [7:0] OFF_IFG = 8'h14;
  localparam logic [7:0] OFF_IES = 8'h18;
  localparam logic [7:0] OFF_CFG = 8'h1C;
  localparam logic [7:0] OFF_STS = 8'h20;

  // ----------------------------------------------------------------
  // Configuration register field positions.
  // ----------------------------------------------------------------
  localparam int CFG_CID_LSB  = 2;
  localparam int CFG_CID_MSB  = 5;
  localparam int CFG_LCDP_LSB = 8;
  localparam int CFG_VLD_LSB  = 12;

  // ----------------------------------------------------------------
  // Reset values and thresholds.
  // ----------------------------------------------------------------
  localparam logic [7:0]        PORT_RST   = 8'h00;
  localparam logic [3:0]        CID_RST    = 4'h0;
  localparam logic [LCDP_W-1:0] LCDP_RST   = 3'h0;
  localparam logic [VLD_W-1:0]  VLD_RST    = 4'h0;
  localparam logic [LCDP_W-1:0] LCDP_SEG   = 3'h4;
  localparam logic [VLD_W-1:0]  VLD_EXTERN = 4'hF;

endpackage

// ---- rtl/p2m_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser with rise and fall pulses for the pin inputs.
module p2m_sync (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [p2m_pkg::PIN_W-1:0] pin_i,
  output logic      [p2m_pkg::PIN_W-1:0] level_o,
  output logic      [p2m_pkg::PIN_W-1:0] rise_o,
  output logic      [p2m_pkg::PIN_W-1:0] fall_o
);

  logic [p2m_pkg::PIN_W-1:0] meta_reg;
  logic [p2m_pkg::PIN_W-1:0] sync_reg;
  logic [p2m_pkg::PIN_W-1:0] prev_reg;

  // Only the second stage reads the first; edges use stages two and three.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge pulses last one cycle.
  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;
  assign fall_o  = ~sync_reg & prev_reg;

endmodule // p2m_sync

`default_nettype wire
